// ===== rtl/cgpe_pkg.sv
// Shared constants and types of the current gauge PWM encoder
package cgpe_pkg;

    // ****************************************************************
    // Clock and PWM timing
    // ****************************************************************
    localparam int CGPE_CLK_HZ      = 250_000_000;  // Core clock, 4 ns period
    localparam int CGPE_PWM_FREQ_HZ = 20;           // Nominal PWM repetition rate
    localparam int CGPE_RAMP_STEPS  = 1024;         // Duty quantisation levels
    // One ramp step in core cycles; one ramp period is one sampling slot
    localparam int CGPE_STEP_CYCLES = CGPE_CLK_HZ / (CGPE_PWM_FREQ_HZ * CGPE_RAMP_STEPS);
    localparam int CGPE_STEP_W      = 14;

    // ****************************************************************
    // Ramp and code layout
    // ****************************************************************
    localparam int CGPE_RAMP_W              = 10;
    localparam logic [9:0] CGPE_RAMP_LAST   = 10'h3ff;
    localparam logic [9:0] CGPE_CODE_ZERO   = 10'h200;  // Zero-current code, mid scale
    localparam logic [9:0] CGPE_CODE_MAX    = 10'h3ff;

    // ****************************************************************
    // Filter and averaging
    // ****************************************************************
    localparam int CGPE_CNT_W               = 24;       // Holds samples of one slot
    localparam int CGPE_DENS_W              = 11;       // Density 0..1024
    localparam logic [10:0] CGPE_DENS_HALF  = 11'h200;  // Density of zero current
    localparam logic [3:0]  CGPE_DIV_LAST   = 4'ha;     // Quotient bit index 10
    // Duty gain: code offset = (density - half) * 1024 / 1.1 / 1024
    localparam logic signed [11:0] CGPE_GAIN = 12'sh3a3; // 931
    localparam int CGPE_GAIN_SHIFT          = 10;

    // Factory full-scale option in amperes (1 or 10); fixed at build time
    localparam int CGPE_FULL_SCALE_A        = 1;

    // ****************************************************************
    // State encodings
    // ****************************************************************
    typedef enum logic [1:0] {
        CGPE_OFF = 2'b01,
        CGPE_RUN = 2'b10
    } cgpe_mode_e;

    typedef enum logic [1:0] {
        CGPE_FLT_ACC = 2'b01,
        CGPE_FLT_DIV = 2'b10
    } cgpe_flt_e;

endpackage

// ===== rtl/cgpe_filter.sv
// Pulse-density filter: per-slot ones count and averaged density divider
module cgpe_filter
    import cgpe_pkg::*;
(
    input  wire logic                   i_mclk,
    input  wire logic                   i_rst_n,
    input  wire logic                   i_clear,
    input  wire logic                   i_pds_valid,
    input  wire logic                   i_pds_bit,
    input  wire logic                   i_slot_end,
    output logic [CGPE_DENS_W-1:0]      o_density,
    output logic                        o_done
);

    // ****************************************************************
    // State
    // ****************************************************************
    cgpe_flt_e               state, next_state;
    logic [CGPE_CNT_W-1:0]   ones, next_ones;
    logic [CGPE_CNT_W-1:0]   total, next_total;
    logic [CGPE_CNT_W:0]     rem, next_rem;
    logic [CGPE_CNT_W-1:0]   divisor, next_divisor;
    logic [CGPE_DENS_W-1:0]  quot, next_quot;
    logic [3:0]              bit_idx, next_bit_idx;
    logic [CGPE_DENS_W-1:0]  next_density;
    logic                    next_done;

    // Boxcar accumulation over the slot, then a bit-serial divide
    always_comb begin
        next_state   = state;
        next_ones    = ones;
        next_total   = total;
        next_rem     = rem;
        next_divisor = divisor;
        next_quot    = quot;
        next_bit_idx = bit_idx;
        next_density = o_density;
        next_done    = 1'b0;
        if (i_slot_end) begin
            // Close the slot; a sample in this cycle opens the next one
            next_ones    = {{(CGPE_CNT_W-1){1'b0}}, i_pds_valid & i_pds_bit}; // R8
            next_total   = {{(CGPE_CNT_W-1){1'b0}}, i_pds_valid};
            next_rem     = {1'b0, ones};
            next_divisor = total;
            next_quot    = '0;
            next_bit_idx = CGPE_DIV_LAST;
            next_state   = CGPE_FLT_DIV;
        end else if (i_pds_valid) begin
            next_ones  = ones + {{(CGPE_CNT_W-1){1'b0}}, i_pds_bit}; // R1
            next_total = total + {{(CGPE_CNT_W-1){1'b0}}, 1'b1};
        end
        case (state)
            CGPE_FLT_ACC: begin
            end
            CGPE_FLT_DIV: begin
                if (!i_slot_end) begin
                    // Restoring division: density = ones * 1024 / total
                    if (rem >= {1'b0, divisor}) begin
                        next_quot[bit_idx] = 1'b1; // R1
                        next_rem = (rem - {1'b0, divisor}) << 1;
                    end else begin
                        next_rem = rem << 1;
                    end
                    if (bit_idx == 4'h0) begin
                        next_state = CGPE_FLT_ACC;
                        next_done  = 1'b1;
                        // An empty slot carries no current information
                        if (divisor == '0) begin
                            next_density = CGPE_DENS_HALF;
                        end else begin
                            next_density = next_quot;
                        end
                    end else begin
                        next_bit_idx = bit_idx - 4'h1;
                    end
                end
            end
            default: begin
                next_state = CGPE_FLT_ACC;
            end
        endcase
        if (i_clear) begin
            next_state   = CGPE_FLT_ACC; // R17
            next_ones    = '0;
            next_total   = '0;
            next_density = CGPE_DENS_HALF;
            next_done    = 1'b0;
        end
    end

    // Register stage
    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            state     <= CGPE_FLT_ACC;
            ones      <= '0;
            total     <= '0;
            rem       <= '0;
            divisor   <= '0;
            quot      <= '0;
            bit_idx   <= '0;
            o_density <= CGPE_DENS_HALF;
            o_done    <= 1'b0;
        end else begin
            state     <= next_state;
            ones      <= next_ones;
            total     <= next_total;
            rem       <= next_rem;
            divisor   <= next_divisor;
            quot      <= next_quot;
            bit_idx   <= next_bit_idx;
            o_density <= next_density;
            o_done    <= next_done;
        end
    end

endmodule

// ===== rtl/cgpe_top.sv
// Current gauge PWM encoder: filter, slot averaging, ramp compare and shutdown
//
// Behaviour
// R1: Filter modulator bitstream into multi-bit current value
// R2: PWM high while ramp below filtered value
// R3: Zero current gives half duty cycle
// R4: Positive current above half, negative below
// R5: Full scale gives 95.5 and 4.5 percent
// R6: Duty equals current over 2.2 full-scale plus half
// R7: Full-scale option fixed at build time
// R8: Average current over whole sampling slots
// R9: Duty quantised to 1024 levels
// R10: Extra half step: duty is (N+0.5)/1024
// R11: Host subtracts 1/2048 from measured duty
// R12: Host may average readings to cut jitter
// R13: PWM repeats at about twenty hertz
// R14: Low shutdown input enters low-power mode
// R15: Duty shows previous slot average current
// R16: Ten-bit ramp; compare loaded only at wrap
// R17: Reset and wake clear state, start mid-code
module cgpe_top
    import cgpe_pkg::*;
#(
    parameter int STEP_CYCLES = CGPE_STEP_CYCLES
)
(
    input  wire logic                   i_mclk,
    input  wire logic                   i_rst_n,
    input  wire logic                   i_low_power_request_n,
    input  wire logic                   i_pds_valid,
    input  wire logic                   i_pds_bit,
    output logic                        o_pwm,
    output logic                        o_active,
    output logic [CGPE_RAMP_W-1:0]      o_code
);

    // ****************************************************************
    // Helpers
    // ****************************************************************

    // Density 0..1024 to duty code; gain 1/1.1 keeps full scale at 95.5 %
    function automatic logic [CGPE_RAMP_W-1:0] map_code(input logic [CGPE_DENS_W-1:0] dens);
        logic signed [CGPE_DENS_W:0]    centred;
        logic signed [23:0]             prod;
        logic signed [23:0]             code;
        centred = $signed({1'b0, dens}) - $signed({1'b0, CGPE_DENS_HALF}); // R4
        // Operands widened first so the product cannot wrap at twelve bits
        prod    = 24'(centred) * 24'(CGPE_GAIN); // R5
        code    = (prod >>> CGPE_GAIN_SHIFT) + $signed({14'h0, CGPE_CODE_ZERO});
        if (code < 0) begin
            map_code = '0;
        end else if (code > $signed({14'h0, CGPE_CODE_MAX})) begin
            map_code = CGPE_CODE_MAX;
        end else begin
            map_code = code[CGPE_RAMP_W-1:0];
        end
    endfunction

    localparam logic [CGPE_STEP_W-1:0] STEP_LAST = CGPE_STEP_W'(STEP_CYCLES - 1);
    localparam logic [CGPE_STEP_W-1:0] STEP_HALF = CGPE_STEP_W'(STEP_CYCLES / 2);

    // ****************************************************************
    // Mode control
    // ****************************************************************
    cgpe_mode_e mode, next_mode;
    logic       clear;

    // Shutdown input is a level; leaving it restarts every counter
    always_comb begin
        next_mode = mode;
        case (mode)
            CGPE_OFF: begin
                if (i_low_power_request_n) begin
                    next_mode = CGPE_RUN;
                end
            end
            CGPE_RUN: begin
                if (!i_low_power_request_n) begin
                    next_mode = CGPE_OFF; // R14
                end
            end
            default: begin
                next_mode = CGPE_OFF;
            end
        endcase
    end

    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            mode <= CGPE_OFF;
        end else begin
            mode <= next_mode;
        end
    end

    // Held in clear for the whole shutdown, so no slot spans it
    assign clear = (mode != CGPE_RUN); // R17

    // ****************************************************************
    // Ramp generator
    // ****************************************************************
    logic [CGPE_STEP_W-1:0] step_cnt, next_step_cnt;
    logic [CGPE_RAMP_W-1:0] ramp, next_ramp;
    logic                   step_wrap;
    logic                   ramp_wrap;
    logic                   slot_end;

    assign step_wrap = (step_cnt == STEP_LAST);
    assign ramp_wrap = step_wrap && (ramp == CGPE_RAMP_LAST); // R16
    // Slot closes at the start of the last step, leaving that step for the divide
    assign slot_end  = (mode == CGPE_RUN) && (ramp == CGPE_RAMP_LAST) && (step_cnt == '0);

    // 1024 steps of STEP_CYCLES each give the ~20 Hz period
    always_comb begin
        next_step_cnt = step_cnt;
        next_ramp     = ramp;
        if (clear) begin
            next_step_cnt = '0; // R17
            next_ramp     = '0;
        end else if (step_wrap) begin
            next_step_cnt = '0; // R13
            next_ramp     = ramp + 10'h001; // R16
        end else begin
            next_step_cnt = step_cnt + 14'h0001;
        end
    end

    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            step_cnt <= '0;
            ramp     <= '0;
        end else begin
            step_cnt <= next_step_cnt;
            ramp     <= next_ramp;
        end
    end

    // ****************************************************************
    // Filter and slot average
    // ****************************************************************
    logic [CGPE_DENS_W-1:0] density;
    logic                   dens_done;

    cgpe_filter u_filter (
        .i_mclk      (i_mclk),
        .i_rst_n     (i_rst_n),
        .i_clear     (clear),
        .i_pds_valid (i_pds_valid & ~clear),
        .i_pds_bit   (i_pds_bit),
        .i_slot_end  (slot_end),
        .o_density   (density),
        .o_done      (dens_done)
    );

    // ****************************************************************
    // Compare value
    // ****************************************************************
    logic [CGPE_RAMP_W-1:0] pending, next_pending;
    logic [CGPE_RAMP_W-1:0] next_code;

    // Result of the closed slot waits for the wrap, so a period never mixes two codes
    always_comb begin
        next_pending = pending;
        next_code    = o_code;
        if (dens_done) begin
            // Ratiometric mapping, so the full-scale option needs no run-time input
            next_pending = map_code(density); // R6 R7
        end
        if (clear) begin
            next_pending = CGPE_CODE_ZERO; // R17
            next_code    = CGPE_CODE_ZERO; // R3
        end else if (ramp_wrap) begin
            next_code = pending; // R15
        end
    end

    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            pending <= CGPE_CODE_ZERO;
            o_code  <= CGPE_CODE_ZERO;
        end else begin
            pending <= next_pending;
            o_code  <= next_code;
        end
    end

    // ****************************************************************
    // PWM output
    // ****************************************************************
    logic next_pwm;

    // High while ramp is below the code, plus half of step N: duty (N+0.5)/1024.
    // Zero current therefore reads 512.5/1024; the host removes the half step.
    always_comb begin
        next_pwm = 1'b0;
        if (!clear) begin
            if (ramp < o_code) begin
                next_pwm = 1'b1; // R2
            end else if ((ramp == o_code) && (step_cnt < STEP_HALF)) begin
                next_pwm = 1'b1; // R10
            end
        end
    end

    // Output parked low in shutdown to save the load current
    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_pwm    <= 1'b0;
            o_active <= 1'b0;
        end else begin
            o_pwm    <= next_pwm; // R9
            o_active <= ~clear;   // R14
        end
    end

endmodule

// ===== tb/cgpe_chk.sv
// Port assertions of the current gauge PWM encoder
module cgpe_chk
    import cgpe_pkg::*;
#(
    parameter int STEP_CYCLES = CGPE_STEP_CYCLES
)
(
    input wire logic                   i_mclk,
    input wire logic                   i_rst_n,
    input wire logic                   i_low_power_request_n,
    input wire logic                   o_pwm,
    input wire logic                   o_active,
    input wire logic [CGPE_RAMP_W-1:0] o_code
);
    timeunit 1ns;
    timeprecision 1ps;

    // ********
    // Helpers
    // ********
    logic        pwm_q;
    logic        seen;
    logic        next_seen;
    logic [23:0] per_cnt;
    logic [23:0] hi_cnt;
    logic [23:0] next_per_cnt;
    logic [23:0] next_hi_cnt;

    // Restart in shutdown so a cut-short pulse is never judged
    always_comb begin
        next_seen    = seen;
        next_per_cnt = per_cnt + 24'h1;
        next_hi_cnt  = o_pwm ? hi_cnt + 24'h1 : 24'h0;
        if (!o_active) begin
            next_seen    = 1'b0;
            next_per_cnt = 24'h0;
        end else if (o_pwm && !pwm_q) begin
            next_seen    = 1'b1;
            next_per_cnt = 24'h0;
        end
    end

    // Registers only
    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            pwm_q   <= 1'b0;
            seen    <= 1'b0;
            per_cnt <= 24'h0;
            hi_cnt  <= 24'h0;
        end else begin
            pwm_q   <= o_pwm;
            seen    <= next_seen;
            per_cnt <= next_per_cnt;
            hi_cnt  <= next_hi_cnt;
        end
    end

    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (!i_rst_n);

    property p_off;
        !i_low_power_request_n [*3] |-> !o_pwm && !o_active && o_code == CGPE_CODE_ZERO;
    endproperty
    a_off: assert property (p_off) else $error("outputs not idle in shutdown");
    property p_wake;
        i_low_power_request_n [*3] |-> o_active;
    endproperty
    a_wake: assert property (p_wake) else $error("not running");
    property p_period;
        o_active && o_pwm && !pwm_q && seen |-> per_cnt == STEP_CYCLES * 1024 - 1;
    endproperty
    a_period: assert property (p_period) else $error("wrong period");
    property p_wrap;
        $changed(o_code) && o_active && $past(o_active) |=> $rose(o_pwm);
    endproperty
    a_wrap: assert property (p_wrap) else $error("code load off wrap");
    property p_high;
        o_active && !o_pwm && pwm_q |-> hi_cnt == o_code * STEP_CYCLES + STEP_CYCLES / 2;
    endproperty
    a_high: assert property (p_high) else $error("wrong high time");
    property p_idle;
        !o_active |-> o_code == CGPE_CODE_ZERO;
    endproperty
    a_idle: assert property (p_idle) else $error("code not zero code");
    property p_fall;
        $fell(o_active) |-> !o_pwm;
    endproperty
    a_fall: assert property (p_fall) else $error("pwm left high");
    property p_range;
        o_active |-> o_code >= 10'h02e && o_code <= 10'h3d1;
    endproperty
    a_range: assert property (p_range) else $error("code out of range");
endmodule

bind cgpe_top cgpe_chk #(.STEP_CYCLES(STEP_CYCLES)) u_chk (.i_mclk(i_mclk), .i_rst_n(i_rst_n),
    .i_low_power_request_n(i_low_power_request_n), .o_pwm(o_pwm), .o_active(o_active), .o_code(o_code));

// ===== tb/cgpe_host_model.sv
// Host model: timer capture of PWM high time and period
module cgpe_host_model
    import cgpe_pkg::*;
#(
    parameter int STEP_CYCLES = CGPE_STEP_CYCLES
)
(
    input  wire logic  i_mclk,
    input  wire logic  i_rst_n,
    input  wire logic  i_pwm,
    output logic [15:0] o_high,
    output logic [15:0] o_corr,
    output logic [15:0] o_period
);
    timeunit 1ns;
    timeprecision 1ps;

    logic        pwm_q;
    logic [15:0] hi_cnt;
    logic [15:0] per_cnt;

    // A rising edge opens each period, so capture there
    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            pwm_q    <= 1'b0;
            hi_cnt   <= 16'h0;
            per_cnt  <= 16'h0;
            o_high   <= 16'h0;
            o_period <= 16'h0;
        end else begin
            pwm_q <= i_pwm;
            if (i_pwm && !pwm_q) begin
                o_high   <= hi_cnt;
                o_period <= per_cnt;
                hi_cnt   <= 16'h1;
                per_cnt  <= 16'h1;
            end else begin
                hi_cnt  <= hi_cnt + {15'h0, i_pwm};
                per_cnt <= per_cnt + 16'h1;
            end
        end
    end

    // Half-step removal so the reading is exactly code times step
    assign o_corr = o_high - 16'(STEP_CYCLES / 2);
endmodule

// ===== tb/cgpe_top_tb.sv
// Self-checking bench of the current gauge PWM encoder
module cgpe_top_tb
    import cgpe_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    // Short step keeps a period at 16384 cycles
    localparam int STEP = 16;
    localparam int SAMPLES = STEP * 1024 - 64;
    localparam logic [3:0] MASK [4] = '{4'hf, 4'h0, 4'h5, 4'h7};

    logic        i_mclk;
    logic        i_rst_n;
    logic        i_low_power_request_n;
    logic        i_pds_valid;
    logic        i_pds_bit;
    logic        o_pwm;
    logic        o_active;
    logic [9:0]  o_code;
    logic [15:0] meas;
    logic [15:0] corr;
    logic [15:0] per;
    int          fails;
    int          num_checks;

    cgpe_top #(.STEP_CYCLES(STEP)) dut (.i_mclk(i_mclk), .i_rst_n(i_rst_n),
        .i_low_power_request_n(i_low_power_request_n), .i_pds_valid(i_pds_valid),
        .i_pds_bit(i_pds_bit), .o_pwm(o_pwm), .o_active(o_active), .o_code(o_code));
    cgpe_host_model #(.STEP_CYCLES(STEP)) u_host (.i_mclk(i_mclk), .i_rst_n(i_rst_n),
        .i_pwm(o_pwm), .o_high(meas), .o_corr(corr), .o_period(per));

    always #2 i_mclk = ~i_mclk;

    // Expected code of a slot filled with one repeating 4-bit pattern
    function automatic logic [9:0] exp_code(input logic [3:0] m);
        int d;
        d = $countones(m) * 256 - 512;
        return 10'(512 + ((d * 931) >>> 10));
    endfunction

    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        num_checks++;
        if (got !== exp) begin
            fails++;
            $display("Error at %0t: got %0h expected %0h", $time, got, exp);
        end
    endtask

    task automatic stop_test();
        $display("checks %0d mismatches %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    // Bounded wait for the next period start
    task automatic wait_rise();
        logic prev;
        int   n;
        prev = o_pwm;
        for (n = 0; n < 20000; n++) begin
            @(negedge i_mclk);
            if (o_pwm === 1'b1 && prev === 1'b0) break;
            prev = o_pwm;
        end
        if (n == 20000) begin
            fails++;
            $display("Error at %0t: no period start", $time);
        end
    endtask

    // Valid stays low near the wrap so each slot holds one pattern only
    task automatic run_slot(input logic [3:0] m);
        for (int i = 0; i < SAMPLES; i++) begin
            i_pds_valid = 1'b1;
            i_pds_bit   = m[i % 4];
            @(negedge i_mclk);
        end
        i_pds_valid = 1'b0;
    endtask

    task automatic t_reset();
        check(o_pwm, 1'b0);
        check(o_active, 1'b0);
        check(o_code, CGPE_CODE_ZERO);
        i_rst_n = 1'b1;
        wait_rise();
        check(o_code, CGPE_CODE_ZERO);
    endtask

    // Full scale both ways, zero and a fractional level, back to back
    task automatic t_levels();
        logic [9:0]  prev;
        logic [17:0] sum_meas;
        logic [17:0] sum_exp;
        prev     = CGPE_CODE_ZERO;
        sum_meas = '0;
        sum_exp  = '0;
        for (int k = 0; k < 4; k++) begin
            run_slot(MASK[k]);
            wait_rise();
            @(negedge i_mclk);
            check(o_code, exp_code(MASK[k]));
            check(meas, 16'(prev * STEP + STEP / 2));
            check(corr, 16'(prev * STEP));
            check(per, 16'(STEP * 1024));
            sum_meas += 18'(meas);
            sum_exp  += 18'(prev * STEP + STEP / 2);
            prev = exp_code(MASK[k]);
        end
        // Host-style mean of four readings against the mean of the expected ones
        check(16'(sum_meas >> 2), 16'(sum_exp >> 2));
    endtask

    // Shutdown in mid-pulse, then wake
    task automatic t_shutdown();
        i_low_power_request_n = 1'b0;
        i_pds_valid           = 1'b1;
        i_pds_bit             = 1'b1;
        repeat (3) @(negedge i_mclk);
        check(o_pwm, 1'b0);
        check(o_active, 1'b0);
        check(o_code, CGPE_CODE_ZERO);
        repeat (20) @(negedge i_mclk);
        i_pds_valid           = 1'b0;
        i_low_power_request_n = 1'b1;
        repeat (3) @(negedge i_mclk);
        check(o_active, 1'b1);
        check(o_code, CGPE_CODE_ZERO);
    endtask

    initial begin
        i_mclk                = 1'b0;
        i_rst_n               = 1'b0;
        i_low_power_request_n = 1'b1;
        i_pds_valid           = 1'b0;
        i_pds_bit             = 1'b0;
        fails                 = 0;
        num_checks            = 0;
        repeat (6) @(negedge i_mclk);
        t_reset();
        t_levels();
        t_shutdown();
        stop_test();
    end

    // Watchdog at about 120000 cycles, well past the planned run
    initial begin
        #480000;
        fails++;
        $display("Error at %0t: watchdog expired", $time);
        stop_test();
    end
endmodule
